// ==== rtl/lrs_fifo.sv ====
`timescale 1ns/1ps
`default_nettype none
module lrs_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 16
) (
   input wire logic   clk,
   input wire logic   rst_n,
   lrs_stream_if.snk  wr,
   lrs_stream_if.src  rd
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wp;
   logic [AW-1:0]    rp;
   logic [AW:0]      cnt;
   logic             do_wr;
   logic             do_rd;

   assign wr.ready = (cnt != (AW+1)'(DEPTH));
   assign rd.valid = (cnt != '0);
   assign rd.data  = mem[rp];
   assign do_wr    = wr.valid && wr.ready;
   assign do_rd    = rd.valid && rd.ready;

   // ==========================================================
   // Storage
   always_ff @(posedge clk) begin
      if (do_wr) begin
         mem[wp] <= wr.data;
      end
   end

   // ==========================================================
   // Pointers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wp  <= '0;
         rp  <= '0;
         cnt <= '0;
      end else begin
         if (do_wr) begin
            wp <= (wp == AW'(DEPTH-1)) ? '0 : wp + 1'b1;
         end
         if (do_rd) begin
            rp <= (rp == AW'(DEPTH-1)) ? '0 : rp + 1'b1;
         end
         cnt <= cnt + (AW+1)'(do_wr) - (AW+1)'(do_rd);
      end
   end
endmodule
`default_nettype wire

// ==== rtl/lrs_pkg.sv ====
//
// Behaviour
// - Receive FIFO holds 64, overwrites oldest when full
// - Run pin high starts descriptor table execution
// - Run pin low stops descriptor execution
// - Fresh received message retransmitted without host
// - Forwarded message still readable from RAM/FIFO
// - Channel 0 label 0 storage at 0x0000
// - Indexed opcode: receive label byte 1, data from storage
// - Status byte set entirely on each reception
// - Consumer clears only its own fresh flag
// - Eight-byte descriptors, table at 0x4000
// - Control bit 6 selects 1 ms tick
// - Tick runs free, latency up to one tick
// - Several descriptors concentrate onto one transmitter
// - Forwarded word carries descriptor transmit label
// - Opcode 0x00 ends the table walk
// - Control run bit cleared: finish pass, stop
// - Period and offset bytes time each descriptor
`default_nettype none
package lrs_pkg;
   // ==========================================================
   // Memory map
   localparam logic [15:0] RX_RAM_BASE  = 16'h0000;
   localparam logic [15:0] DESC_BASE    = 16'h4000;
   localparam logic [15:0] CTRL_ADDR    = 16'h8040;
   localparam logic [15:0] STAT_ADDR    = 16'h8041;
   localparam logic [15:0] PASS_ADDR    = 16'h8042;
   localparam logic [15:0] RXCNT_BASE   = 16'h8050;
   localparam logic [15:0] RXFIFO_BASE  = 16'h8080;
   // ==========================================================
   // Control fields
   localparam int          CTRL_RUN_BIT  = 0;
   localparam int          CTRL_TICK_BIT = 6;
   localparam logic [7:0]  CTRL_RESET    = 8'h00;
   localparam logic [7:0]  STATUS_FRESH  = 8'hff;
   // ==========================================================
   // Descriptor layout
   localparam int          DESC_BYTES = 8;
   localparam logic [2:0]  DB_OPCODE  = 3'h0;
   localparam logic [2:0]  DB_RXLABEL = 3'h1;
   localparam logic [2:0]  DB_PERIOD  = 3'h2;
   localparam logic [2:0]  DB_OFFSET  = 3'h3;
   localparam logic [2:0]  DB_TXLABEL = 3'h4;
   localparam logic [2:0]  DB_DATA1   = 3'h5;
   localparam logic [2:0]  DB_DATA2   = 3'h6;
   localparam logic [2:0]  DB_DATA3   = 3'h7;
   localparam logic [7:0]  OP_TABLE_TERMINATOR = 8'h00;
   localparam logic [3:0]  OP_IMMEDIATE        = 4'h1;
   localparam logic [3:0]  OP_DELAY            = 4'h2;
   localparam logic [3:0]  OP_INDEXED_COND     = 4'h5;
   // ==========================================================
   // Sizes and timing
   localparam int          RX_MSG_BYTES  = 4;
   localparam int          RXF_DEPTH_DEF = 64;
   localparam int          TXF_DEPTH_DEF = 16;
   localparam int          CLK_MHZ       = 125;
   localparam int          TICK_MS_US    = 1000;
   localparam int          TICK_FAST_US  = 100;
   localparam int          TICK_MS_CYC   = TICK_MS_US * CLK_MHZ;
   localparam int          TICK_FAST_CYC = TICK_FAST_US * CLK_MHZ;
   // ==========================================================
   // Scheduler states
   typedef enum logic [3:0] {
      S_IDLE  = 4'b0001,
      S_STEP  = 4'b0010,
      S_PUSH  = 4'b0100,
      S_DELAY = 4'b1000
   } lrs_state_t;
endpackage
`default_nettype wire

// ==== rtl/lrs_scheduler.sv ====
// Design decisions made here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module lrs_scheduler
   import lrs_pkg::*;
#(
   parameter int NUM_RX        = 4,
   parameter int TX_CH         = 0,
   parameter int DESC_DEPTH    = 32,
   parameter int RXF_DEPTH     = RXF_DEPTH_DEF,
   parameter int TXF_DEPTH     = TXF_DEPTH_DEF,
   parameter int TICK_MS_CYCS  = TICK_MS_CYC,
   parameter int TICK_FAST_CYCS = TICK_FAST_CYC
) (
   input  wire logic                       clk,
   input  wire logic                       rst_n,
   input  wire logic                       run_pin,
   input  wire logic [15:0]                reg_addr,
   input  wire logic [7:0]                 reg_wdata,
   input  wire logic                       reg_wr,
   input  wire logic                       reg_rd,
   output logic      [7:0]                 reg_rdata,
   input  wire logic                       rx_valid,
   input  wire logic [$clog2(NUM_RX)-1:0]  rx_ch,
   input  wire logic [7:0]                 rx_label,
   input  wire logic [23:0]                rx_data,
   output logic                            tx_valid,
   output logic      [31:0]                tx_word,
   input  wire logic                       tx_ready,
   output logic                            sched_busy
);
   localparam int CHW    = $clog2(NUM_RX);
   localparam int RAW    = CHW + 10;
   localparam int RX_SZ  = NUM_RX * 256 * RX_MSG_BYTES;
   localparam int DAW    = $clog2(DESC_DEPTH * DESC_BYTES);
   localparam int IW     = $clog2(DESC_DEPTH + 1);
   localparam int FAW    = $clog2(RXF_DEPTH);
   localparam int FCW    = $clog2(RXF_DEPTH + 1);

   // ==========================================================
   // Reset and run pin synchronisers
   logic       rst_meta_n;
   logic       rst_sync_n;
   logic       run_meta;
   logic       run_sync;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta_n <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         rst_meta_n <= 1'b1;
         rst_sync_n <= rst_meta_n;
      end
   end

   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         run_meta <= 1'b0;
         run_sync <= 1'b0;
      end else begin
         run_meta <= run_pin;
         run_sync <= run_meta;
      end
   end

   // ==========================================================
   // Memories and control register
   logic [7:0]      rx_ram   [RX_SZ];
   logic [7:0]      desc_ram [DESC_DEPTH * DESC_BYTES];
   logic [7:0]      ctrl;
   logic [7:0]      pass_cnt;
   lrs_state_t      state;
   logic [IW-1:0]   idx;
   logic [7:0]      dly_cnt;
   logic            tick;
   logic [23:0]     tick_cnt;

   logic            host_rx_hit;
   logic            host_desc_hit;
   logic [RAW-1:0]  rx_wr_base;
   logic            clr_en;
   logic [RAW-1:0]  clr_addr;

   assign host_rx_hit   = (reg_addr < 16'(RX_SZ));
   assign host_desc_hit = (reg_addr >= DESC_BASE) &&
                          (reg_addr < DESC_BASE + 16'(DESC_DEPTH * DESC_BYTES));
   assign rx_wr_base    = {rx_ch, rx_label, 2'b00};

   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         ctrl <= CTRL_RESET;
      end else if (reg_wr && reg_addr == CTRL_ADDR) begin
         ctrl <= reg_wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (reg_wr && host_desc_hit) begin
         desc_ram[DAW'(reg_addr - DESC_BASE)] <= reg_wdata;
      end
   end

   // Reception last: set wins
   always_ff @(posedge clk) begin
      if (reg_wr && host_rx_hit) begin
         rx_ram[RAW'(reg_addr)] <= reg_wdata;
      end
      if (clr_en) begin
         rx_ram[clr_addr][TX_CH] <= 1'b0;
      end
      if (rx_valid) begin
         rx_ram[rx_wr_base]          <= STATUS_FRESH;
         rx_ram[rx_wr_base + RAW'(1)] <= rx_data[23:16];
         rx_ram[rx_wr_base + RAW'(2)] <= rx_data[15:8];
         rx_ram[rx_wr_base + RAW'(3)] <= rx_data[7:0];
      end
   end

   // ==========================================================
   // Free running scheduler tick
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         tick_cnt <= '0;
         tick     <= 1'b0;
      end else begin
         tick <= 1'b0;
         if (ctrl[CTRL_TICK_BIT] ? (tick_cnt >= 24'(TICK_MS_CYCS - 1))
                                 : (tick_cnt >= 24'(TICK_FAST_CYCS - 1))) begin
            tick_cnt <= '0;
            tick     <= 1'b1;
         end else begin
            tick_cnt <= tick_cnt + 24'h1;
         end
      end
   end

   // ==========================================================
   // Current descriptor decode
   logic [DAW-1:0]  dbase;
   logic [7:0]      d_op;
   logic [3:0]      d_code;
   logic [CHW-1:0]  d_ch;
   logic [7:0]      d_period;
   logic [7:0]      d_offset;
   logic [RAW-1:0]  src_base;
   logic            d_due;
   logic            d_fresh;
   logic            table_end;

   assign dbase     = DAW'(idx) << 3;
   assign d_op      = desc_ram[dbase + DAW'(DB_OPCODE)];
   assign d_code    = d_op[7:4];
   assign d_ch      = CHW'(d_op[3:0]);
   assign d_period  = desc_ram[dbase + DAW'(DB_PERIOD)];
   assign d_offset  = desc_ram[dbase + DAW'(DB_OFFSET)];
   assign src_base  = {d_ch, desc_ram[dbase + DAW'(DB_RXLABEL)], 2'b00};
   assign d_fresh   = rx_ram[src_base][TX_CH];
   assign d_due     = (d_period == 8'h00) ||
                      ((pass_cnt % d_period) == d_offset);
   assign table_end = (idx == IW'(DESC_DEPTH)) ||
                      (d_op == OP_TABLE_TERMINATOR);

   assign clr_en   = (state == S_STEP) && run_sync && !table_end &&
                     (d_code == OP_INDEXED_COND) && d_due && d_fresh;
   assign clr_addr = src_base;

   // ==========================================================
   // Transmit path buffer
   lrs_stream_if #(.WIDTH(32)) tx_in ();
   lrs_stream_if #(.WIDTH(32)) tx_out ();
   logic [31:0] word;

   lrs_fifo #(
      .WIDTH (32),
      .DEPTH (TXF_DEPTH)
   ) u_txf (
      .clk   (clk),
      .rst_n (rst_sync_n),
      .wr    (tx_in),
      .rd    (tx_out)
   );

   assign tx_in.valid  = (state == S_PUSH);
   assign tx_in.data   = word;
   assign tx_out.ready = !tx_valid || tx_ready;

   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         tx_valid <= 1'b0;
         tx_word  <= '0;
      end else if (tx_out.ready) begin
         tx_valid <= tx_out.valid;
         if (tx_out.valid) begin
            tx_word <= tx_out.data;
         end
      end
   end

   // ==========================================================
   // Scheduler sequencer
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         state    <= S_IDLE;
         idx      <= '0;
         pass_cnt <= '0;
         dly_cnt  <= '0;
         word     <= '0;
      end else if (!run_sync) begin
         state <= S_IDLE;
         idx   <= '0;
      end else begin
         case (state)
            S_IDLE: begin
               // A pass starts only while the control run bit is set;
               // clearing it lets the pass in progress finish once
               if (tick && ctrl[CTRL_RUN_BIT]) begin
                  state    <= S_STEP;
                  idx      <= '0;
                  pass_cnt <= pass_cnt + 8'h1;
               end
            end
            S_STEP: begin
               if (table_end) begin
                  state <= S_IDLE;
               end else if (d_code == OP_INDEXED_COND) begin
                  if (d_due && d_fresh) begin
                     word  <= {desc_ram[dbase + DAW'(DB_TXLABEL)],
                               rx_ram[src_base + RAW'(1)],
                               rx_ram[src_base + RAW'(2)],
                               rx_ram[src_base + RAW'(3)]};
                     state <= S_PUSH;
                  end else begin
                     idx <= idx + IW'(1);
                  end
               end else if (d_code == OP_IMMEDIATE) begin
                  if (d_due) begin
                     word  <= {desc_ram[dbase + DAW'(DB_TXLABEL)],
                               desc_ram[dbase + DAW'(DB_DATA1)],
                               desc_ram[dbase + DAW'(DB_DATA2)],
                               desc_ram[dbase + DAW'(DB_DATA3)]};
                     state <= S_PUSH;
                  end else begin
                     idx <= idx + IW'(1);
                  end
               end else if (d_code == OP_DELAY && d_period != 8'h00) begin
                  dly_cnt <= d_period;
                  state   <= S_DELAY;
               end else begin
                  idx <= idx + IW'(1);
               end
            end
            S_PUSH: begin
               if (tx_in.ready) begin
                  idx   <= idx + IW'(1);
                  state <= S_STEP;
               end
            end
            S_DELAY: begin
               if (tick) begin
                  if (dly_cnt == 8'h01) begin
                     idx   <= idx + IW'(1);
                     state <= S_STEP;
                  end
                  dly_cnt <= dly_cnt - 8'h1;
               end
            end
            default: begin
               state <= S_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         sched_busy <= 1'b0;
      end else begin
         sched_busy <= (state != S_IDLE);
      end
   end

   // ==========================================================
   // Receive FIFOs, one per channel
   logic [NUM_RX-1:0][31:0]    rxf_head;
   logic [NUM_RX-1:0][FCW-1:0] rxf_cnt;
   logic                       fifo_hit;
   logic [CHW-1:0]             fifo_ch;

   assign fifo_hit = (reg_addr >= RXFIFO_BASE) &&
                     (reg_addr < RXFIFO_BASE + 16'(NUM_RX * RX_MSG_BYTES));
   assign fifo_ch  = CHW'((reg_addr - RXFIFO_BASE) >> 2);

   for (genvar g = 0; g < NUM_RX; g++) begin : g_rxf
      logic [31:0]    mem [RXF_DEPTH];
      logic [FAW-1:0] wp;
      logic [FAW-1:0] rp;
      logic [FCW-1:0] cnt;
      logic           push;
      logic           pop;
      logic           full;

      assign push = rx_valid && (rx_ch == CHW'(g));
      assign pop  = reg_rd && fifo_hit && (fifo_ch == CHW'(g)) &&
                    (reg_addr[1:0] == 2'b11) && (cnt != '0);
      assign full = (cnt == FCW'(RXF_DEPTH));
      assign rxf_head[g] = mem[rp];
      assign rxf_cnt[g]  = cnt;

      always_ff @(posedge clk) begin
         if (push) begin
            mem[wp] <= {rx_label, rx_data};
         end
      end

      always_ff @(posedge clk or negedge rst_sync_n) begin
         if (!rst_sync_n) begin
            wp  <= '0;
            rp  <= '0;
            cnt <= '0;
         end else begin
            if (push) begin
               wp <= (wp == FAW'(RXF_DEPTH - 1)) ? '0 : wp + FAW'(1);
            end
            if (pop || (push && full)) begin
               rp <= (rp == FAW'(RXF_DEPTH - 1)) ? '0 : rp + FAW'(1);
            end
            if (push && !pop && !full) begin
               cnt <= cnt + FCW'(1);
            end else if (pop && !push) begin
               cnt <= cnt - FCW'(1);
            end
         end
      end
   end

   // ==========================================================
   // Register read port
   logic [7:0] next_rdata;
   logic [31:0] head_sel;

   assign head_sel = rxf_head[fifo_ch];

   always_comb begin
      next_rdata = 8'h00;
      if (host_rx_hit) begin
         next_rdata = rx_ram[RAW'(reg_addr)];
      end else if (host_desc_hit) begin
         next_rdata = desc_ram[DAW'(reg_addr - DESC_BASE)];
      end else if (reg_addr == CTRL_ADDR) begin
         next_rdata = ctrl;
      end else if (reg_addr == STAT_ADDR) begin
         next_rdata = {4'h0, state};
      end else if (reg_addr == PASS_ADDR) begin
         next_rdata = pass_cnt;
      end else if (reg_addr >= RXCNT_BASE &&
                   reg_addr < RXCNT_BASE + 16'(NUM_RX)) begin
         next_rdata = 8'(rxf_cnt[CHW'(reg_addr - RXCNT_BASE)]);
      end else if (fifo_hit) begin
         case (reg_addr[1:0])
            2'b00:   next_rdata = head_sel[31:24];
            2'b01:   next_rdata = head_sel[23:16];
            2'b10:   next_rdata = head_sel[15:8];
            default: next_rdata = head_sel[7:0];
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         reg_rdata <= next_rdata;
      end else begin
         reg_rdata <= 8'h00;
      end
   end
endmodule
`default_nettype wire

// ==== rtl/lrs_stream_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface lrs_stream_if #(parameter int WIDTH = 32);
   logic             valid;
   logic             ready;
   logic [WIDTH-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ==== test/lrs_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
module lrs_monitor
   import lrs_pkg::*;
#(
   parameter int NUM_RX         = 4,
   parameter int CHW            = $clog2(NUM_RX),
   parameter int RXF_DEPTH      = RXF_DEPTH_DEF,
   parameter int TICK_FAST_CYCS = TICK_FAST_CYC
) (
   input wire logic           clk,
   input wire logic           rst_n,
   input wire logic           run_pin,
   input wire logic [15:0]    reg_addr,
   input wire logic [7:0]     reg_wdata,
   input wire logic           reg_wr,
   input wire logic           reg_rd,
   input wire logic [7:0]     reg_rdata,
   input wire logic           rx_valid,
   input wire logic [CHW-1:0] rx_ch,
   input wire logic [7:0]     rx_label,
   input wire logic [23:0]    rx_data,
   input wire logic           tx_valid,
   input wire logic [31:0]    tx_word,
   input wire logic           tx_ready,
   input wire logic           sched_busy
);
   logic [15:0] stat_q;
   logic [7:0]  run_hist, busy_hist;
   int          gap;
   default clocking @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   // ==========================================================
   // Helper state
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stat_q <= 16'h0000;
         run_hist <= 8'h00;
         busy_hist <= 8'h00;
         gap <= TICK_FAST_CYCS;
      end else begin
         run_hist <= {run_hist[6:0], run_pin};
         busy_hist <= {busy_hist[6:0], sched_busy};
         if (rx_valid) begin
            stat_q <= RX_RAM_BASE + 16'(rx_ch) * 16'h0400 + 16'(rx_label) * 16'h0004;
         end
         if (reg_wr && reg_addr == CTRL_ADDR) begin
            gap <= TICK_FAST_CYCS;
         end else if (sched_busy && !busy_hist[0]) begin
            gap <= 1;
         end else if (gap < TICK_FAST_CYCS) begin
            gap <= gap + 1;
         end
      end
   end
   // ==========================================================
   // Sequences and assertions
   sequence s_rx_probe;
      rx_valid ##1 !rx_valid ##1 (reg_rd && !rx_valid && reg_addr == stat_q);
   endsequence
   sequence s_run_low;
      !run_pin [*6];
   endsequence
   AST_STATUS_SET: assert property (s_rx_probe |=> reg_rdata == STATUS_FRESH)
      else $error("status not all ones");
   AST_RUN_STOP: assert property (s_run_low |-> !sched_busy)
      else $error("busy with run low");
   AST_RUN_START: assert property ($rose(sched_busy) |-> run_hist != 8'h00)
      else $error("start without run");
   AST_TX_CAUSE: assert property ($rose(tx_valid) |-> busy_hist != 8'h00)
      else $error("word without pass");
   AST_TX_HOLD: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_word))
      else $error("word not held");
   AST_RDATA_PULSE: assert property (!reg_rd ##1 1'b1 |-> reg_rdata == 8'h00)
      else $error("read data not zero");
   AST_UNMAPPED: assert property (reg_rd && reg_addr[15:12] == 4'h9 |=> reg_rdata == 8'h00)
      else $error("unmapped not zero");
   AST_FIFO_COUNT: assert property (reg_rd && reg_addr >= RXCNT_BASE
      && reg_addr < RXCNT_BASE + 16'(NUM_RX) |=> reg_rdata <= 8'(RXF_DEPTH))
      else $error("count above depth");
   AST_TICK_GAP: assert property ($rose(sched_busy) |-> gap >= TICK_FAST_CYCS)
      else $error("passes too close");
endmodule
bind lrs_scheduler lrs_monitor #(
   .NUM_RX(NUM_RX), .RXF_DEPTH(RXF_DEPTH), .TICK_FAST_CYCS(TICK_FAST_CYCS)
) u_mon (.*);
`default_nettype wire

// ==== test/lrs_tx_sink.sv ====
`timescale 1ns/1ps
`default_nettype none
module lrs_tx_sink (
   input wire logic        clk,
   input wire logic        rst_n,
   input wire logic [1:0]  stall,
   input wire logic        tx_valid,
   input wire logic [31:0] tx_word,
   output logic            tx_ready
);
   logic [31:0] got[$];
   int          stamp[$];
   int          cyc = 0;
   // ==========================================================
   // Ready: prompt, toggling or held
   initial tx_ready = 1'b0;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (rst_n && tx_valid && tx_ready) begin
         got.push_back(tx_word);
         stamp.push_back(cyc);
      end
      if (!rst_n || stall == 2'h2) tx_ready <= 1'b0;
      else if (stall == 2'h1) tx_ready <= !tx_ready;
      else tx_ready <= 1'b1;
   end
endmodule
`default_nettype wire

// ==== test/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb
   import lrs_pkg::*;
;
   localparam int TMS = 50, TFAST = 20;
   logic        clk, rst_n, run_pin, reg_wr, reg_rd, rx_valid, tx_valid, tx_ready, sched_busy;
   logic [15:0] reg_addr;
   logic [7:0]  reg_wdata, reg_rdata, rx_label;
   logic [1:0]  rx_ch, stall;
   logic [23:0] rx_data;
   logic [31:0] tx_word;
   int          failures = 0, n_compared = 0, cycles = 0, n;
   // ==========================================================
   // Design and far side
   lrs_scheduler #(.DESC_DEPTH(8), .TICK_MS_CYCS(TMS), .TICK_FAST_CYCS(TFAST)) dut (.*);
   lrs_tx_sink sink (.*);
   // ==========================================================
   // Tasks
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
      n_compared++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [15:0] a, input logic [7:0] exp);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      chk($sformatf("reg %h", a), exp, reg_rdata);
   endtask
   task automatic rx(input logic [1:0] ch, input logic [7:0] lab, input logic [23:0] d);
      @(posedge clk);
      rx_valid <= 1'b1;
      rx_ch <= ch;
      rx_label <= lab;
      rx_data <= d;
      @(posedge clk);
      rx_valid <= 1'b0;
   endtask
   task automatic desc(input int i, input logic [7:0] op, per, off, txl, d1, d2, d3);
      logic [7:0] b [8] = '{op, 8'h00, per, off, txl, d1, d2, d3};
      for (int k = 0; k < 8; k++) wr(DESC_BASE + 16'(i * 8 + k), b[k]);
   endtask
   task automatic words(input int cnt, input int lim);
      int t = 0;
      while (sink.got.size() < cnt && t < lim) begin
         @(posedge clk);
         t++;
      end
      chk("words", cnt, sink.got.size());
   endtask
   task automatic results;
      $display("compared %0d mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // ==========================================================
   // Clock and timeout
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         failures++;
         $display("CHECK FAILED timeout expected finish seen hang");
         results();
      end
   end
   // ==========================================================
   // Tests
   initial begin
      {rst_n, run_pin, reg_wr, reg_rd, rx_valid} = 5'h00;
      {reg_addr, reg_wdata, rx_ch, rx_label, rx_data, stall} = 60'h0;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      chk("busy", 0, sched_busy);
      rd(CTRL_ADDR, CTRL_RESET);
      rd(16'h9000, 8'h00);
      rx(2'h0, 8'h00, 24'h023456);
      rd(RX_RAM_BASE, STATUS_FRESH);
      rd(16'h0001, 8'h02);
      rd(16'h0003, 8'h56);
      $display("test storage done");
      desc(0, {OP_INDEXED_COND, 4'h0}, 0, 0, 8'h02, 0, 0, 0);
      wr(DESC_BASE + 16'h0008, OP_TABLE_TERMINATOR);
      wr(CTRL_ADDR, 8'h41);
      @(posedge clk) run_pin <= 1'b1;
      words(1, 3 * TMS);
      chk("repeat", 32'h02023456, sink.got[0]);
      sink.got.delete();
      rx(2'h0, 8'h00, 24'h0a0b0c);
      words(1, TMS + 10);
      chk("repeat2", 32'h020a0b0c, sink.got[0]);
      repeat (3 * TMS) @(posedge clk);
      chk("no resend", 1, sink.got.size());
      rd(RX_RAM_BASE, 8'hfe);
      rd(RXFIFO_BASE, 8'h00);
      rd(RXFIFO_BASE + 16'h0003, 8'h56);
      rd(RXCNT_BASE, 8'h01);
      @(posedge clk) run_pin <= 1'b0;
      rx(2'h0, 8'h00, 24'h112233);
      repeat (3 * TMS) @(posedge clk);
      chk("stopped", 1, sink.got.size());
      $display("test repeater done");
      desc(0, 8'h50, 0, 0, 8'h11, 0, 0, 0);
      desc(1, 8'h51, 0, 0, 8'h22, 0, 0, 0);
      wr(DESC_BASE + 16'h0010, OP_TABLE_TERMINATOR);
      desc(3, 8'h10, 0, 0, 8'h77, 0, 0, 0);
      rx(2'h1, 8'h00, 24'h03789a);
      sink.got.delete();
      stall <= 2'h1;
      @(posedge clk) run_pin <= 1'b1;
      words(2, 3 * TMS);
      repeat (3 * TMS) @(posedge clk);
      chk("count", 2, sink.got.size());
      chk("conc0", 32'h11112233, sink.got[0]);
      chk("conc1", 32'h2203789a, sink.got[1]);
      @(posedge clk) run_pin <= 1'b0;
      $display("test concentrator done");
      for (int i = 0; i < 65; i++) rx(2'h2, 8'(i), 24'(i));
      rd(RXCNT_BASE + 16'h0002, 8'h40);
      rd(RXFIFO_BASE + 16'h0008, 8'h01);
      $display("test overwrite done");
      stall <= 2'h0;
      desc(0, {OP_IMMEDIATE, 4'h0}, 0, 0, 8'h44, 8'h01, 8'h02, 8'h03);
      wr(DESC_BASE + 16'h0008, OP_TABLE_TERMINATOR);
      sink.got.delete();
      sink.stamp.delete();
      @(posedge clk) run_pin <= 1'b1;
      words(4, 5 * TMS);
      chk("imm", 32'h44010203, sink.got[3]);
      chk("slow", TMS, sink.stamp[3] - sink.stamp[2]);
      wr(CTRL_ADDR, 8'h01);
      sink.got.delete();
      sink.stamp.delete();
      words(4, 6 * TFAST);
      chk("fast", TFAST, sink.stamp[3] - sink.stamp[2]);
      $display("test tick done");
      @(posedge clk) run_pin <= 1'b0;
      repeat (10) @(posedge clk);
      desc(0, {OP_IMMEDIATE, 4'h0}, 0, 0, 8'ha1, 0, 0, 0);
      desc(1, {OP_IMMEDIATE, 4'h0}, 8'h02, 8'h01, 8'hb2, 0, 0, 0);
      wr(DESC_BASE + 16'h0010, OP_TABLE_TERMINATOR);
      sink.got.delete();
      @(posedge clk) run_pin <= 1'b1;
      words(12, 20 * TFAST);
      n = 0;
      for (int j = 0; j < 12; j++) n += int'(sink.got[j][31:24] == 8'hb2);
      chk("period", 4, n);
      for (int j = 3; j < 12; j++) chk("phase", sink.got[j - 3][31:24], sink.got[j][31:24]);
      @(posedge clk) run_pin <= 1'b0;
      repeat (10) @(posedge clk);
      $display("test period done");
      for (int k = 0; k < 7; k++) desc(k, 8'h10, 0, 0, 8'h30 + 8'(k), 8'ha5, 8'(k), ~8'(k));
      wr(DESC_BASE + 16'h0038, OP_TABLE_TERMINATOR);
      sink.got.delete();
      stall <= 2'h2;
      @(posedge clk) run_pin <= 1'b1;
      repeat (8 * TFAST) @(posedge clk);
      chk("full stall", 1, sched_busy);
      wr(CTRL_ADDR, 8'h00);
      stall <= 2'h0;
      repeat (6 * TFAST) @(posedge clk);
      n = sink.got.size();
      chk("whole", 0, n % 7);
      chk("filled", 1, n >= 16);
      chk("idle", 0, sched_busy || tx_valid);
      for (int j = 0; j < n; j++) chk("pass", {8'h30 + 8'(j % 7), 8'ha5, 8'(j % 7),
         ~8'(j % 7)}, sink.got[j]);
      $display("test one-time done");
      results();
   end
endmodule
`default_nettype wire
